// ===== design/irq_event_block.sv
/*
 * Interrupt status and enable logic of the embedded host controller.
 * Sticky event flags, set-only enables, global enable, level interrupt request,
 * overrun tally and the fault halt. Assumes every input, bus commands included,
 * comes from logic on I_CLK; the bus interface delivers one command per pulse.
 */

module irq_event_block
	import irq_event_pkg::*;
(
	input  wire logic        I_CLK,
	input  wire logic        I_RSTN,
	input  wire logic        I_SW_RESET,
	input  wire logic        I_CMD_VALID,
	input  wire logic [7:0]  I_CMD_CODE,
	input  wire logic [31:0] I_CMD_WDATA,
	input  wire logic [31:0] I_ROOT_HUB_STATE,
	input  wire logic [31:0] I_PORT1_STATE,
	input  wire logic [31:0] I_PORT2_STATE,
	input  wire logic [15:0] I_FRAME_INDEX,
	input  wire logic        I_SYS_FAULT,
	input  wire logic        I_REMOTE_RESUME,
	input  wire logic        I_SW_RESUME,
	input  wire logic        I_FRAME_START,
	input  wire logic        I_SCHED_OVERRUN,
	output logic             O_IRQ,
	output logic [31:0]      O_RDATA,
	output logic             O_RDATA_VALID,
	output logic [1:0]       O_OVERRUN_TALLY,
	output logic             O_HALT,
	output logic             O_SOF_REQUEST
);

	// ==========================================================
	// State
	logic [31:0] flags;
	logic [31:0] enables;
	logic [31:0] prev_root;
	logic [31:0] prev_port1;
	logic [31:0] prev_port2;
	logic        prev_msb;
	logic        prev_resume;
	logic        track_valid;

	logic [31:0] next_flags;
	logic [31:0] next_enables;
	logic [31:0] next_rdata;
	logic        next_rdata_valid;
	logic [1:0]  next_tally;
	logic        next_halt;
	logic        next_irq;
	logic [31:0] set_bits;
	logic [31:0] clr_bits;
	logic        wr_flags;
	logic        wr_enables;
	logic        any_reset;
	logic        next_sof;
	logic        next_track;

	// ==========================================================
	// Next values
	always_comb begin
		any_reset  = !I_RSTN || I_SW_RESET;
		wr_flags   = I_CMD_VALID && (I_CMD_CODE == CODE_FLAGS_WR);
		wr_enables = I_CMD_VALID && (I_CMD_CODE == CODE_ENABLES_WR);

		set_bits = '0;
		// The first cycle after reset only primes the trackers, so no false change
		if (track_valid) begin
			set_bits[BIT_ROOT_PORT_CHANGE] = (I_ROOT_HUB_STATE != prev_root) ||
				(I_PORT1_STATE != prev_port1) || (I_PORT2_STATE != prev_port2);
			set_bits[BIT_FRAME_COUNT_WRAP] = I_FRAME_INDEX[BIT_FRAME_INDEX_MSB] != prev_msb;
			set_bits[BIT_RESUME_DETECTED]  = I_REMOTE_RESUME && !prev_resume && !I_SW_RESUME;
		end
		set_bits[BIT_FATAL_SYSTEM_FAULT] = I_SYS_FAULT;
		set_bits[BIT_FRAME_BEGIN]        = I_FRAME_START;
		set_bits[BIT_SCHED_OVERRUN]      = I_SCHED_OVERRUN;

		clr_bits = wr_flags ? (I_CMD_WDATA & FLAGS_MASK) : '0;
		// An event in the clearing cycle wins, so nothing is lost
		next_flags = ((flags & ~clr_bits) | set_bits) & FLAGS_MASK;

		next_enables = enables;
		if (wr_enables)
			next_enables = enables | (I_CMD_WDATA & ENABLES_MASK);

		next_tally = O_OVERRUN_TALLY;
		if (I_SCHED_OVERRUN)
			next_tally = O_OVERRUN_TALLY + TALLY_STEP;

		next_halt = O_HALT || I_SYS_FAULT;

		next_sof   = I_FRAME_START;
		next_track = 1'b1;

		// Registered level: built from the next flags, so it rises and drops in the same cycle as the flags
		next_irq = (|(next_flags & next_enables & FLAGS_MASK)) &&
			next_enables[BIT_GLOBAL_IRQ_ENABLE];

		next_rdata       = '0;
		next_rdata_valid = 1'b0;
		if (I_CMD_VALID && (I_CMD_CODE == CODE_FLAGS_RD)) begin
			next_rdata       = flags & FLAGS_MASK;
			next_rdata_valid = 1'b1;
		end else if (I_CMD_VALID && (I_CMD_CODE == CODE_ENABLES_RD)) begin
			next_rdata       = enables & ENABLES_MASK;
			next_rdata_valid = 1'b1;
		end

		if (any_reset) begin
			next_flags   = FLAGS_RESET;
			next_enables = ENABLES_RESET;
			next_tally   = TALLY_RESET;
			next_halt    = 1'b0;
			next_irq     = 1'b0;
			next_sof     = 1'b0;
			next_track   = 1'b0;
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge I_CLK) begin
		flags           <= next_flags;
		enables         <= next_enables;
		O_OVERRUN_TALLY <= next_tally;
		O_HALT          <= next_halt;
		O_IRQ           <= next_irq;
		O_RDATA         <= next_rdata;
		O_RDATA_VALID   <= next_rdata_valid;
		O_SOF_REQUEST   <= next_sof;
		prev_root       <= I_ROOT_HUB_STATE;
		prev_port1      <= I_PORT1_STATE;
		prev_port2      <= I_PORT2_STATE;
		prev_msb        <= I_FRAME_INDEX[BIT_FRAME_INDEX_MSB];
		prev_resume     <= I_REMOTE_RESUME;
		track_valid     <= next_track;
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RSTN || I_SW_RESET);

	logic quiet_next;
	assign quiet_next = I_RSTN && !I_SW_RESET;

	sequence seq_fault_seen;
		I_SYS_FAULT && quiet_next;
	endsequence

	sequence seq_halt_hold;
		O_HALT && flags[BIT_FATAL_SYSTEM_FAULT] ##1 O_HALT;
	endsequence

	chk_fault_halts: assert property (seq_fault_seen |=> seq_halt_hold)
		else $error("Fault did not set flag and halt");

	chk_flag_w1c: assert property (wr_flags && I_CMD_WDATA[BIT_FRAME_BEGIN] && !I_FRAME_START && quiet_next
		|=> !flags[BIT_FRAME_BEGIN])
		else $error("Write of one did not clear flag");

	chk_flag_sticky: assert property (flags[BIT_SCHED_OVERRUN] && !wr_flags && quiet_next
		|=> flags[BIT_SCHED_OVERRUN])
		else $error("Flag dropped without a clear");

	chk_set_wins: assert property (wr_flags && I_CMD_WDATA[BIT_SCHED_OVERRUN] && I_SCHED_OVERRUN && quiet_next
		|=> flags[BIT_SCHED_OVERRUN])
		else $error("Event lost against clear");

	chk_irq_cause: assert property (O_IRQ |-> enables[BIT_GLOBAL_IRQ_ENABLE] && |(flags & enables))
		else $error("Interrupt without enabled flag");

	chk_irq_raise: assert property (|(flags & enables & FLAGS_MASK) && enables[BIT_GLOBAL_IRQ_ENABLE]
		&& !wr_flags && quiet_next |=> O_IRQ)
		else $error("Interrupt not raised");

	chk_enable_set: assert property (wr_enables && quiet_next
		|=> (enables & ENABLES_MASK) == (($past(enables) | $past(I_CMD_WDATA)) & ENABLES_MASK))
		else $error("Enable write wrong");

	chk_enable_read: assert property (I_CMD_VALID && I_CMD_CODE == CODE_ENABLES_RD && quiet_next
		|=> O_RDATA_VALID && O_RDATA == $past(enables))
		else $error("Enable read wrong");

	chk_wrap_flag: assert property (track_valid && I_FRAME_INDEX[BIT_FRAME_INDEX_MSB] != prev_msb
		&& quiet_next |=> flags[BIT_FRAME_COUNT_WRAP])
		else $error("Frame wrap not flagged");

	chk_sof_pair: assert property (I_FRAME_START && quiet_next
		|=> O_SOF_REQUEST && flags[BIT_FRAME_BEGIN])
		else $error("Frame start not handled");

	chk_tally_step: assert property (I_SCHED_OVERRUN && quiet_next
		|=> O_OVERRUN_TALLY == $past(O_OVERRUN_TALLY) + TALLY_STEP && flags[BIT_SCHED_OVERRUN])
		else $error("Tally not stepped with flag");

	chk_reserved_zero: assert property (O_RDATA_VALID |-> (O_RDATA & ~ENABLES_MASK) == '0)
		else $error("Reserved bits read nonzero");

	// ==========================================================
	// Register bus checks
	sequence seq_flags_read;
		I_CMD_VALID && I_CMD_CODE == CODE_FLAGS_RD && quiet_next;
	endsequence

	sequence seq_flags_answer;
		O_RDATA_VALID && O_RDATA == $past(flags);
	endsequence

	chk_flags_read: assert property (seq_flags_read |=> seq_flags_answer)
		else $error("Flag read wrong");

	// Read data is zero when idle so a stale word cannot be mistaken for an answer
	chk_read_idle: assert property (!(I_CMD_VALID && (I_CMD_CODE == CODE_FLAGS_RD ||
		I_CMD_CODE == CODE_ENABLES_RD)) && quiet_next |=> !O_RDATA_VALID && O_RDATA == '0)
		else $error("Read answer without read");

	chk_flags_rsvd: assert property ((flags & ~FLAGS_MASK) == '0)
		else $error("Reserved flag bit set");

	chk_enables_rsvd: assert property ((enables & ~ENABLES_MASK) == '0)
		else $error("Reserved enable bit set");

	chk_enable_keep: assert property (!wr_enables && quiet_next |=> enables == $past(enables))
		else $error("Enables changed without write");

	chk_enable_no_drop: assert property (wr_enables && quiet_next
		|=> (enables & $past(enables)) == $past(enables))
		else $error("Enable write dropped a bit");

	chk_global_set: assert property (wr_enables && I_CMD_WDATA[BIT_GLOBAL_IRQ_ENABLE] && quiet_next
		|=> enables[BIT_GLOBAL_IRQ_ENABLE])
		else $error("Global enable not set");

	chk_global_keep: assert property (enables[BIT_GLOBAL_IRQ_ENABLE] && quiet_next
		|=> enables[BIT_GLOBAL_IRQ_ENABLE])
		else $error("Global enable dropped");

	chk_clear_keeps: assert property (wr_flags && !I_CMD_WDATA[BIT_SCHED_OVERRUN] &&
		flags[BIT_SCHED_OVERRUN] && quiet_next |=> flags[BIT_SCHED_OVERRUN])
		else $error("Write of zero cleared flag");

	chk_write_no_set: assert property (wr_flags && !I_FRAME_START && !flags[BIT_FRAME_BEGIN] &&
		quiet_next |=> !flags[BIT_FRAME_BEGIN])
		else $error("Flag write set a flag");

	// ==========================================================
	// Interrupt request checks
	chk_irq_match: assert property (O_IRQ == ((|(flags & enables & FLAGS_MASK)) &&
		enables[BIT_GLOBAL_IRQ_ENABLE]))
		else $error("Interrupt level out of step");

	chk_irq_global_off: assert property (!enables[BIT_GLOBAL_IRQ_ENABLE] |-> !O_IRQ)
		else $error("Interrupt without global enable");

	chk_irq_gate_pos: assert property (O_IRQ |-> |(flags & enables & FLAGS_MASK))
		else $error("Interrupt from unmatched bit");

	// ==========================================================
	// Event checks
	sequence seq_resume_rise;
		track_valid && I_REMOTE_RESUME && !prev_resume && quiet_next;
	endsequence

	sequence seq_overrun_seen;
		I_SCHED_OVERRUN && quiet_next;
	endsequence

	chk_root_change: assert property (track_valid && I_ROOT_HUB_STATE != prev_root && quiet_next
		|=> flags[BIT_ROOT_PORT_CHANGE])
		else $error("Hub change not flagged");

	chk_port_change: assert property (track_valid && (I_PORT1_STATE != prev_port1 ||
		I_PORT2_STATE != prev_port2) && quiet_next |=> flags[BIT_ROOT_PORT_CHANGE])
		else $error("Port change not flagged");

	// The trackers hold junk in the first cycle after reset, so no change is reported then
	chk_track_prime: assert property (!track_valid && !flags[BIT_ROOT_PORT_CHANGE] && quiet_next
		|=> !flags[BIT_ROOT_PORT_CHANGE])
		else $error("False change after reset");

	chk_wrap_quiet: assert property (track_valid && I_FRAME_INDEX[BIT_FRAME_INDEX_MSB] == prev_msb &&
		!flags[BIT_FRAME_COUNT_WRAP] && quiet_next |=> !flags[BIT_FRAME_COUNT_WRAP])
		else $error("Wrap flag without toggle");

	chk_resume_flag: assert property (seq_resume_rise and !I_SW_RESUME
		|=> flags[BIT_RESUME_DETECTED])
		else $error("Remote resume not flagged");

	chk_resume_sw: assert property (I_SW_RESUME && !flags[BIT_RESUME_DETECTED] && quiet_next
		|=> !flags[BIT_RESUME_DETECTED])
		else $error("Resume flagged in software resume");

	chk_sof_pulse: assert property (!I_FRAME_START && quiet_next |=> !O_SOF_REQUEST)
		else $error("Frame request without frame start");

	chk_sof_quiet: assert property (!I_FRAME_START && !flags[BIT_FRAME_BEGIN] && quiet_next
		|=> !flags[BIT_FRAME_BEGIN])
		else $error("Frame flag without frame start");

	chk_overrun_flag: assert property (seq_overrun_seen |=> flags[BIT_SCHED_OVERRUN])
		else $error("Overrun not flagged");

	chk_tally_hold: assert property (!I_SCHED_OVERRUN && quiet_next
		|=> O_OVERRUN_TALLY == $past(O_OVERRUN_TALLY))
		else $error("Tally moved without overrun");

	chk_tally_wrap: assert property (seq_overrun_seen and &O_OVERRUN_TALLY
		|=> O_OVERRUN_TALLY == TALLY_RESET)
		else $error("Tally did not wrap");

	chk_halt_hold: assert property (O_HALT && quiet_next |=> O_HALT)
		else $error("Halt dropped before reset");

	chk_halt_cause: assert property (!O_HALT && !I_SYS_FAULT && quiet_next |=> !O_HALT)
		else $error("Halt without fault");

	chk_fault_sticky: assert property (flags[BIT_FATAL_SYSTEM_FAULT] &&
		!(wr_flags && I_CMD_WDATA[BIT_FATAL_SYSTEM_FAULT]) && quiet_next |=> flags[BIT_FATAL_SYSTEM_FAULT])
		else $error("Fault flag dropped without clear");

	// ==========================================================
	// Reset checks, live during reset itself
	chk_reset_clears: assert property (@(posedge I_CLK) disable iff (1'b0) any_reset
		|=> flags == FLAGS_RESET && !O_IRQ)
		else $error("Reset left flags set");

	chk_reset_state: assert property (@(posedge I_CLK) disable iff (1'b0) any_reset
		|=> O_OVERRUN_TALLY == TALLY_RESET && !O_HALT && enables == ENABLES_RESET && !O_SOF_REQUEST)
		else $error("Reset left state set");

endmodule

// ===== shared/irq_event_pkg.sv
/*
 * Constants for the interrupt status and enable block of the host controller:
 * command codes, field positions, masks and reset values.
 * Assumes the bus interface presents register accesses as one-cycle commands.
 */
package irq_event_pkg;

	// ==========================================================
	// Command codes of the parallel host bus
	localparam logic [7:0]  CODE_FLAGS_RD   = 8'h03;
	localparam logic [7:0]  CODE_FLAGS_WR   = 8'h83;
	localparam logic [7:0]  CODE_ENABLES_RD = 8'h04;
	localparam logic [7:0]  CODE_ENABLES_WR = 8'h84;

	// ==========================================================
	// Bit positions shared by both registers, the enables-only global enable bit and the frame index MSB
	localparam int          BIT_ROOT_PORT_CHANGE   = 6;
	localparam int          BIT_FRAME_COUNT_WRAP   = 5;
	localparam int          BIT_FATAL_SYSTEM_FAULT = 4;
	localparam int          BIT_RESUME_DETECTED    = 3;
	localparam int          BIT_FRAME_BEGIN        = 2;
	localparam int          BIT_SCHED_OVERRUN      = 0;
	localparam int          BIT_GLOBAL_IRQ_ENABLE  = 31;
	localparam int          BIT_FRAME_INDEX_MSB    = 15;

	// ==========================================================
	// Implemented bits, reset values and the tally step
	localparam logic [31:0] FLAGS_MASK     = 32'h0000007d;
	localparam logic [31:0] ENABLES_MASK   = 32'h8000007d;
	localparam logic [31:0] FLAGS_RESET    = 32'h00000000;
	localparam logic [31:0] ENABLES_RESET  = 32'h00000000;
	localparam logic [1:0]  TALLY_RESET    = 2'h0;
	localparam logic [1:0]  TALLY_STEP     = 2'h1;

endpackage

// ===== verification/host_bus_model.sv
/* Host processor model: issues one-cycle register commands, returns read data.
   Assumes the block answers a read exactly one cycle after the strobe. */
module host_bus_model (
	input  wire logic        i_clk,
	input  wire logic [31:0] i_rdata,
	output logic             o_valid,
	output logic [7:0]       o_code,
	output logic [31:0]      o_wdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		o_valid = 1'b0;
		o_code  = 8'h00;
		o_wdata = 32'h0;
	end
	// Released data is inverted so a stale word never looks live
	task automatic access(input logic [7:0] c, input logic [31:0] d, output logic [31:0] r);
		@(posedge i_clk);
		#5;
		o_valid = 1'b1;
		o_code  = c;
		o_wdata = d;
		@(posedge i_clk);
		#5;
		r       = i_rdata;
		o_valid = 1'b0;
		o_wdata = ~d;
	endtask
endmodule

// ===== verification/usb_host_irq_status_enable_tb_top.sv
/* Self-checking bench of the interrupt flag and enable block.
   Assumes the host model above drives the command port. */
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
	$display("MISMATCH %s exp %h got %h", n, e, g); end end
module usb_host_irq_status_enable_tb_top import irq_event_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rstn, sw_rst, vld, fault, rres, swres, fst, ovr, irq, rv, halt, sof;
	logic [7:0] code;
	logic [1:0] tally;
	logic [15:0] frame;
	logic [31:0] wd, rdata, hub, p1, p2, en, tmp;
	int bad_count, checked;
	int bits[5] = '{6, 5, 3, 2, 0};
	irq_event_block i_irq_event_block (.I_CLK(clk), .I_RSTN(rstn), .I_SW_RESET(sw_rst), .I_CMD_VALID(vld),
		.I_CMD_CODE(code), .I_CMD_WDATA(wd), .I_ROOT_HUB_STATE(hub), .I_PORT1_STATE(p1), .I_PORT2_STATE(p2),
		.I_FRAME_INDEX(frame), .I_SYS_FAULT(fault), .I_REMOTE_RESUME(rres), .I_SW_RESUME(swres),
		.I_FRAME_START(fst), .I_SCHED_OVERRUN(ovr), .O_IRQ(irq), .O_RDATA(rdata), .O_RDATA_VALID(rv),
		.O_OVERRUN_TALLY(tally), .O_HALT(halt), .O_SOF_REQUEST(sof));
	host_bus_model i_host_bus_model (.i_clk(clk), .i_rdata(rdata), .o_valid(vld), .o_code(code), .o_wdata(wd));
	// ==========================================================
	// Access tasks
	task automatic wr(input logic [7:0] c, input logic [31:0] d);
		i_host_bus_model.access(c, d, tmp);
	endtask
	task automatic rdc(input logic [7:0] c, input logic [31:0] e, input string n);
		logic [31:0] v;
		i_host_bus_model.access(c, 32'h0, v);
		`CHK(n, e, v)
		`CHK("valid", (c == CODE_FLAGS_RD) || (c == CODE_ENABLES_RD), rv)
	endtask
	// Events are held one edge, so each sets its flag exactly once
	task automatic fire(input int b);
		@(posedge clk);
		#5;
		case (b)
			8: p2 = ~p2;
			7: p1 = ~p1;
			6: hub = hub + 32'h1;
			5: frame[15] = ~frame[15];
			4: fault = 1'b1;
			3: rres = 1'b1;
			2: fst = 1'b1;
			default: ovr = 1'b1;
		endcase
		@(posedge clk);
		#5;
		{fault, rres, fst, ovr} = 4'h0;
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		#2000000;
		bad_count++;
		end_sim();
	end
	// ==========================================================
	// Tests
	initial begin
		{rstn, sw_rst, fault, rres, swres, fst, ovr} = 7'h0;
		{hub, p1, p2, en, frame} = '0;
		repeat (12) @(posedge clk);
		#5;
		rstn = 1'b1;
		rdc(CODE_FLAGS_RD, FLAGS_RESET, "flags");
		rdc(CODE_ENABLES_RD, ENABLES_RESET, "enables");
		`CHK("tally", TALLY_RESET, tally)
		$display("reset test done");
		foreach (bits[i]) begin
			fire(bits[i]);
			`CHK("sof", bits[i] == 2, sof)
			rdc(CODE_FLAGS_RD, 32'h1 << bits[i], "flag");
			en = en | (32'h1 << bits[i]);
			wr(CODE_ENABLES_WR, 32'h1 << bits[i]);
			`CHK("irq gate", i > 0, irq)
			wr(CODE_ENABLES_WR, 32'h8000_0000);
			`CHK("irq on", 1'b1, irq)
			wr(CODE_ENABLES_WR, 32'h0);
			rdc(CODE_ENABLES_RD, en | 32'h8000_0000, "enables");
			wr(CODE_FLAGS_WR, ~(32'h1 << bits[i]));
			rdc(CODE_FLAGS_RD, 32'h1 << bits[i], "flag kept");
			wr(CODE_FLAGS_WR, 32'h1 << bits[i]);
			`CHK("irq drop", 1'b0, irq)
		end
		`CHK("tally", 2'h1, tally)
		@(posedge clk);
		#5;
		ovr = 1'b1;
		repeat (3) @(posedge clk);
		#5;
		ovr = 1'b0;
		`CHK("tally wrap", 2'h0, tally)
		swres = 1'b1;
		fire(3);
		swres = 1'b0;
		rdc(CODE_FLAGS_RD, 32'h1, "no resume");
		fire(7);
		rdc(CODE_FLAGS_RD, 32'h41, "port1");
		wr(CODE_FLAGS_WR, 32'h40);
		fire(8);
		rdc(CODE_FLAGS_RD, 32'h41, "port2");
		wr(CODE_FLAGS_WR, 32'h40);
		$display("event test done");
		fire(4);
		`CHK("halt", 1'b1, halt)
		rdc(CODE_FLAGS_RD, 32'h11, "fault");
		@(posedge clk);
		#5;
		sw_rst = 1'b1;
		@(posedge clk);
		#5;
		sw_rst = 1'b0;
		`CHK("halt clr", 1'b0, halt)
		wr(CODE_FLAGS_WR, 32'h10);
		rdc(CODE_FLAGS_RD, 32'h0, "flags");
		wr(CODE_ENABLES_WR, 32'hffff_ffff);
		rdc(CODE_ENABLES_RD, ENABLES_MASK, "rsvd");
		rdc(8'h7f, 32'h0, "bad code");
		fire(2);
		`CHK("irq", 1'b1, irq)
		@(posedge clk);
		#5;
		rstn = 1'b0;
		@(posedge clk);
		#5;
		rstn = 1'b1;
		`CHK("irq rst", 1'b0, irq)
		rdc(CODE_FLAGS_RD, 32'h0, "flags");
		$display("reset and fault test done");
		end_sim();
	end
endmodule
